// file: src/standby_pkg.sv
// Constants, types and the register map of the standby and hang-up reset block
// ----------------------------------------------------------------------------
// Summary of operation
// RL1: Either standby mode halts execution, keeping registers and memory intact.
// RL2: Oscillator-stop mode gates off the system clock until release.
// RL3: Oscillator-stop while timer counts: halt now, stop clock after countdown.
// RL4: Clock-running halt keeps the clock alive while the processor waits.
// RL5: Operand bits 1..0 pick release source: serial, key scan, key input, timer.
// RL6: Operand bit 3 picks release level for pins; timer needs bit 3 zero.
// RL7: Serial source with accumulator rotate routing releases standby at once.
// RL8: Key scan port releases standby only while in input direction.
// RL9: Driving the all-clear pin low resets processor state and program counter.
// RL10: Low-voltage reset drives the transmit-activity indicator low.
// RL11: Mask option selects one-half or one-third duty for divide-by-twelve.
// RL12: Key-scan-all option resets in oscillator stop on input mode or low pin.
// RL13: Sources marked unused reset the system when their condition occurs.
// RL14: Software issues a no-operation before standby when watchdog is unused.
// RL15: Control bit 6 chooses clock-running halt or oscillator stop.
// RL16: Control bit 0 feeds accumulator MSB or serial pin into rotate-left.
// RL17: Release resumes after the standby instruction, restarting clock first.
// ----------------------------------------------------------------------------
package standby_pkg;
    // Register byte offsets and bus width
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] OPT_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Control register fields
    localparam int CTRL_W = 10;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam int CTRL_ROT_SRC_BIT = 0;
    localparam int CTRL_KEY_OUT_BIT = 1;
    localparam int CTRL_TIMER_RUN_BIT = 2;
    localparam int CTRL_DIV12_BIT = 3;
    localparam int CTRL_OSC_STOP_BIT = 6;
    // Option word fields: byte 1 bit 4 duty, byte 2 bits 7..4 hang-up
    localparam int OPT_DUTY_BIT = 12;
    localparam int OPT_HANG_LSB = 20;
    localparam logic OPT_DUTY_RESET = 1'b0;
    localparam logic [3:0] OPT_HANG_RESET = 4'h0;
    localparam int HANG_KEYIN = 0;
    localparam int HANG_KEYSCAN = 1;
    localparam int HANG_SERIAL = 2;
    localparam int HANG_ALL = 3;
    // Release source encodings from the operand
    localparam logic [1:0] SRC_SERIAL = 2'h0;
    localparam logic [1:0] SRC_KEYSCAN = 2'h1;
    localparam logic [1:0] SRC_KEYIN = 2'h2;
    localparam logic [1:0] SRC_TIMER = 2'h3;
    localparam int OP_LEVEL_BIT = 3;
    // Oscillator restart settle count in clock cycles
    localparam logic [3:0] OSC_RESTART_CYC = 4'h4;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_HALT = 5'h02,
        ST_STOP_WAIT = 5'h04,
        ST_STOP = 5'h08,
        ST_RESTART = 5'h10
    } standby_state_e;

    typedef struct packed {
        logic valid;
        logic [3:0] operand;
    } standby_cmd_s;

    typedef struct packed {
        standby_state_e st;
        logic [9:0] ctrl;
        logic opt_duty;
        logic [3:0] opt_hang;
        logic [1:0] rel_sel;
        logic rel_level;
        logic [3:0] cnt;
        logic resume;
        logic hang_rst;
        logic sys_reset;
        logic tx_ind;
        logic aw_have;
        logic [3:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;
endpackage

// file: src/standby_ctrl.sv
// Standby entry, release, oscillator gating and hang-up reset with AXI4-Lite
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module standby_ctrl
    import standby_pkg::*;
(
    input wire logic clk, // 200 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire standby_cmd_s standby_cmd, // Standby instruction strobe
    input wire logic timer_busy, // Timer countdown in progress
    input wire logic timer_done, // Countdown reached zero, pulse
    input wire logic serial_in, // Serial input pin level
    input wire logic [7:0] key_scan_in, // Key scan port pin levels
    input wire logic [3:0] key_input_port, // Key input port levels
    input wire logic all_clear_pin_n, // All-clear pin, active low
    input wire logic lvd_reset, // Low-voltage detector reset
    input wire logic tx_idle, // High when no carrier is sent
    output logic cpu_halt, // Processor frozen
    output logic sys_clk_en, // System oscillator enable
    output logic resume, // Pulse: continue after standby
    output logic sys_reset, // Processor reset incl. counter
    output logic tx_indicator, // Transmit-activity indicator
    output logic rotate_from_serial, // Rotate-left LSB source
    output logic key_scan_output_mode, // Key scan port drives pins
    output logic timer_run, // Timer count enable
    output logic carrier_div12, // Divide-by-twelve carrier
    output logic carrier_duty_third, // One-third duty selected
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready // Read ready
);
    // ------------------------------------------------------------------------
    // Release and hang-up condition decoding
    // ------------------------------------------------------------------------
    // Raw mode ignores the rotate routing, so hang-up sees only real pins
    function automatic logic src_met(input logic [1:0] sel, input logic lvl,
                                     input logic raw, input logic [9:0] ctl,
                                     input logic sin, input logic [7:0] ks,
                                     input logic [3:0] kin, input logic tdone);
        logic met;
        met = 1'b0;
        case (sel)
            SRC_SERIAL:
                if (!raw && !ctl[CTRL_ROT_SRC_BIT])
                    met = 1'b1; // RL7
                else
                    met = (sin == lvl); // RL6
            SRC_KEYSCAN:
                met = !ctl[CTRL_KEY_OUT_BIT] && (lvl ? |ks : !(&ks)); // RL8
            SRC_KEYIN:
                met = lvl ? |kin : !(&kin); // RL6
            SRC_TIMER:
                met = !lvl && tdone; // RL6
            default:
                met = 1'b0;
        endcase
        return met;
    endfunction

    state_s s;
    state_s next_s;
    logic clear_in;
    logic release_met;
    logic in_standby;
    logic hang_cond;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic [31:0] opt_word;

    assign clear_in = !all_clear_pin_n || lvd_reset || s.hang_rst;
    assign in_standby = (s.st == ST_HALT) || (s.st == ST_STOP_WAIT) ||
                        (s.st == ST_STOP);
    assign release_met = src_met(s.rel_sel, s.rel_level, 1'b0, s.ctrl,
                                 serial_in, key_scan_in, key_input_port,
                                 timer_done); // RL5

    // Unused sources and the key-scan-all check turn a wake into a reset
    always_comb
    begin
        hang_cond = 1'b0;
        if (in_standby)
        begin
            if (s.opt_hang[HANG_SERIAL] &&
                src_met(SRC_SERIAL, s.rel_level, 1'b1, s.ctrl, serial_in,
                        key_scan_in, key_input_port, timer_done))
                hang_cond = 1'b1; // RL13
            if (s.opt_hang[HANG_KEYSCAN] &&
                src_met(SRC_KEYSCAN, s.rel_level, 1'b1, s.ctrl, serial_in,
                        key_scan_in, key_input_port, timer_done))
                hang_cond = 1'b1; // RL13
            if (s.opt_hang[HANG_KEYIN] &&
                src_met(SRC_KEYIN, s.rel_level, 1'b1, s.ctrl, serial_in,
                        key_scan_in, key_input_port, timer_done))
                hang_cond = 1'b1; // RL13
        end
        if (s.st == ST_STOP && s.opt_hang[HANG_ALL] &&
            (!s.ctrl[CTRL_KEY_OUT_BIT] || !(&key_scan_in)))
            hang_cond = 1'b1; // RL12
    end

    // ------------------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------------------
    assign wmask = {{8{s.w_strb[3]}}, {8{s.w_strb[2]}},
                    {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};
    assign ctrl_word = {22'h000000, s.ctrl};
    assign opt_word = {8'h00, s.opt_hang, 7'h00, s.opt_duty, 12'h000};

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.resume = 1'b0;
        next_s.hang_rst = 1'b0;
        next_s.sys_reset = clear_in;
        next_s.tx_ind = lvd_reset ? 1'b0 : tx_idle; // RL10
        // Standby sequencing; registers stay untouched while halted
        case (s.st)
            ST_RUN:
                if (standby_cmd.valid)
                begin
                    next_s.rel_sel = standby_cmd.operand[1:0]; // RL5
                    next_s.rel_level = standby_cmd.operand[OP_LEVEL_BIT];
                    if (!s.ctrl[CTRL_OSC_STOP_BIT])
                        next_s.st = ST_HALT; // RL15
                    else if (timer_busy)
                        next_s.st = ST_STOP_WAIT; // RL3
                    else
                        next_s.st = ST_STOP; // RL15
                end
            ST_HALT:
                if (hang_cond)
                    next_s.hang_rst = 1'b1; // RL13
                else if (release_met)
                begin
                    next_s.st = ST_RUN; // RL4
                    next_s.resume = 1'b1; // RL17
                end
            ST_STOP_WAIT:
                if (hang_cond)
                    next_s.hang_rst = 1'b1; // RL13
                else if (release_met)
                begin
                    next_s.st = ST_RUN;
                    next_s.resume = 1'b1; // RL17
                end
                else if (!timer_busy)
                    next_s.st = ST_STOP; // RL3
            ST_STOP:
                if (hang_cond)
                    next_s.hang_rst = 1'b1; // RL12
                else if (release_met)
                begin
                    next_s.st = ST_RESTART; // RL17
                    next_s.cnt = OSC_RESTART_CYC - 4'h1;
                end
            ST_RESTART:
                if (s.cnt == 4'h0)
                begin
                    next_s.st = ST_RUN;
                    next_s.resume = 1'b1; // RL17
                end
                else
                    next_s.cnt = s.cnt - 4'h1;
            default:
                next_s.st = ST_RUN;
        endcase
        // AXI write: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_s.aw_have = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_s.w_have = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.aw_have && s.w_have)
        begin
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            case ({s.aw_addr[3:2], 2'b00})
                CTRL_OFS:
                    next_s.ctrl = CTRL_W'((ctrl_word & ~wmask) |
                                          (s.w_data & wmask));
                OPT_OFS:
                begin
                    if (s.w_strb[1])
                        next_s.opt_duty = s.w_data[OPT_DUTY_BIT]; // RL11
                    if (s.w_strb[2])
                        next_s.opt_hang = s.w_data[OPT_HANG_LSB +: 4];
                end
                STAT_OFS:
                    next_s.bresp = RESP_OKAY;
                default:
                    next_s.bresp = RESP_SLVERR;
            endcase
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        // AXI read: one read under way, answer one cycle after the address
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                CTRL_OFS:
                    next_s.rdata = ctrl_word;
                OPT_OFS:
                    next_s.rdata = opt_word;
                STAT_OFS:
                    next_s.rdata = {23'h000000, s.rel_level, s.rel_sel,
                                    s.st, cpu_halt};
                default:
                begin
                    next_s.rdata = 32'h00000000;
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end
        // All-clear, low voltage and hang-up put the core back to run
        if (clear_in)
        begin
            next_s.st = ST_RUN; // RL9
            next_s.ctrl = CTRL_RESET; // RL9
            next_s.cnt = 4'h0;
        end
    end

    // State register; options survive pin resets, only rst clears them
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.st <= ST_RUN;
            s.ctrl <= CTRL_RESET;
            s.opt_duty <= OPT_DUTY_RESET;
            s.opt_hang <= OPT_HANG_RESET;
            s.sys_reset <= 1'b1;
            s.tx_ind <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign cpu_halt = (s.st != ST_RUN); // RL1
    assign sys_clk_en = (s.st != ST_STOP); // RL2
    assign resume = s.resume;
    assign sys_reset = s.sys_reset || s.hang_rst; // RL9
    assign tx_indicator = s.tx_ind;
    assign rotate_from_serial = s.ctrl[CTRL_ROT_SRC_BIT]; // RL16
    assign key_scan_output_mode = s.ctrl[CTRL_KEY_OUT_BIT];
    assign timer_run = s.ctrl[CTRL_TIMER_RUN_BIT];
    assign carrier_div12 = s.ctrl[CTRL_DIV12_BIT];
    // Duty only matters for the divide-by-twelve carrier
    assign carrier_duty_third = s.ctrl[CTRL_DIV12_BIT] && s.opt_duty; // RL11
    assign s_axi_awready = !s.aw_have && !s.bvalid;
    assign s_axi_wready = !s.w_have && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    localparam int RESTART_MAX = 16;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_enter_halt;
        standby_cmd.valid && s.st == ST_RUN && !clear_in |=> cpu_halt;
    endproperty
    a_enter_halt: assert property (p_enter_halt) // RL1
        else $error("standby entry did not halt the core");

    property p_stop_clock;
        s.st == ST_STOP |-> !sys_clk_en && cpu_halt;
    endproperty
    a_stop_clock: assert property (p_stop_clock) // RL2
        else $error("clock runs in oscillator stop");

    property p_stop_wait;
        standby_cmd.valid && s.st == ST_RUN && !clear_in && timer_busy &&
        s.ctrl[CTRL_OSC_STOP_BIT] |=> sys_clk_en && s.st == ST_STOP_WAIT;
    endproperty
    a_stop_wait: assert property (p_stop_wait) // RL3
        else $error("oscillator stopped while timer counting");

    property p_halt_clock;
        s.st == ST_HALT |-> sys_clk_en && cpu_halt;
    endproperty
    a_halt_clock: assert property (p_halt_clock) // RL4
        else $error("clock-running halt lost its clock");

    property p_keyin_release;
        s.st == ST_HALT && s.rel_sel == SRC_KEYIN && s.rel_level &&
        (|key_input_port) && s.opt_hang == 4'h0 && !clear_in
        |=> resume && !cpu_halt;
    endproperty
    a_keyin_release: assert property (p_keyin_release) // RL6
        else $error("key input high did not release halt");

    property p_serial_route;
        s.st == ST_HALT && s.rel_sel == SRC_SERIAL &&
        !s.ctrl[CTRL_ROT_SRC_BIT] && s.opt_hang == 4'h0 && !clear_in
        |=> resume;
    endproperty
    a_serial_route: assert property (p_serial_route) // RL7
        else $error("accumulator routing did not release at once");

    property p_keyscan_out;
        s.st == ST_HALT && s.rel_sel == SRC_KEYSCAN &&
        s.ctrl[CTRL_KEY_OUT_BIT] |=> !resume;
    endproperty
    a_keyscan_out: assert property (p_keyscan_out) // RL8
        else $error("key scan released while in output mode");

    property p_all_clear;
        !all_clear_pin_n |=> sys_reset && s.st == ST_RUN;
    endproperty
    a_all_clear: assert property (p_all_clear) // RL9
        else $error("all-clear did not reset the core");

    property p_lvd_indicator;
        lvd_reset |=> !tx_indicator;
    endproperty
    a_lvd_indicator: assert property (p_lvd_indicator) // RL10
        else $error("indicator not low under low-voltage reset");

    property p_keyscan_all;
        s.st == ST_STOP && s.opt_hang[HANG_ALL] &&
        !s.ctrl[CTRL_KEY_OUT_BIT] && !clear_in |=> sys_reset ##1 sys_reset;
    endproperty
    a_keyscan_all: assert property (p_keyscan_all) // RL12
        else $error("key-scan-all hang-up gave no reset");

    property p_unused_keyin;
        s.st == ST_HALT && s.opt_hang[HANG_KEYIN] && s.rel_level &&
        (|key_input_port) && !clear_in |=> sys_reset && !resume;
    endproperty
    a_unused_keyin: assert property (p_unused_keyin) // RL13
        else $error("unused key input source did not reset");

    // A control write with byte 0 strobed must reach the rotate source select
    property p_rotate_src;
        s.aw_have && s.w_have && s.aw_addr[3:2] == 2'h0 && s.w_strb[0] &&
        !clear_in |=> rotate_from_serial == $past(s.w_data[CTRL_ROT_SRC_BIT]);
    endproperty
    a_rotate_src: assert property (p_rotate_src) // RL16
        else $error("rotate source does not follow control bit 0");

    property p_restart;
        s.st == ST_RESTART |-> sys_clk_en && cpu_halt ##[0:RESTART_MAX]
            (resume || clear_in);
    endproperty
    a_restart: assert property (p_restart) // RL17
        else $error("clock restart never resumed execution");

    c_halt_release: cover property (s.st == ST_HALT ##1 resume);
    c_stop_restart: cover property (s.st == ST_STOP ##1 s.st == ST_RESTART);
    c_wait_to_stop: cover property (s.st == ST_STOP_WAIT ##1 s.st == ST_STOP);
    c_hang_reset: cover property (s.hang_rst);
endmodule

// file: sim/key_matrix_model.sv
// Key switches and serial line seen by the standby block
`timescale 1ns/1ps
module key_matrix_model (
    input wire logic press, // Key held down
    input wire logic [1:0] sel, // Port that carries the key
    input wire logic lvl, // Level a pressed key shows
    output logic serial_in, // Serial input line
    output logic [7:0] key_scan_in, // Key scan pins
    output logic [3:0] key_input_port // Key input pins
);
    // Idle lines rest at the opposite level, so nothing releases early
    assign serial_in = (press && sel == 2'h0) ? lvl : !lvl;
    assign key_scan_in = {8{(press && sel == 2'h1) ? lvl : !lvl}};
    assign key_input_port = {4{(press && sel == 2'h2) ? lvl : !lvl}};
endmodule

// file: sim/standby_release_and_hangup_reset_tb.sv
// Self-checking bench for the standby release and hang-up reset block
`timescale 1ns/1ps
module standby_release_and_hangup_reset_tb import standby_pkg::*;;
    logic clk = 0, rst = 1, busy = 0, tdone = 0, press = 0, lvl = 0;
    logic clr_n = 1, lvd = 0, idle = 1, awv = 0, wv = 0, bry = 0;
    logic arv = 0, rry = 0, sin, halt, clk_en, resume, sys_reset, tx_ind;
    logic duty3, awr, wr_rdy, bv, arr, rv;
    logic [1:0] sel = 0, bresp, rresp, rs, got;
    logic [3:0] awa = 0, ara = 0, co, key_in;
    logic [7:0] ks;
    logic [31:0] wd = 0, rdata, rd, k;
    standby_cmd_s cmd = '0;
    int bad_count = 0, total_checks = 0, seed = 87742, n, i, s;

    always #2.5 clk = ~clk;

    key_matrix_model far (.press(press), .sel(sel), .lvl(lvl),
        .serial_in(sin), .key_scan_in(ks), .key_input_port(key_in));

    standby_ctrl dut (.clk(clk), .rst(rst), .standby_cmd(cmd),
        .timer_busy(busy), .timer_done(tdone), .serial_in(sin),
        .key_scan_in(ks), .key_input_port(key_in), .all_clear_pin_n(clr_n),
        .lvd_reset(lvd), .tx_idle(idle), .cpu_halt(halt),
        .sys_clk_en(clk_en), .resume(resume), .sys_reset(sys_reset),
        .tx_indicator(tx_ind), .rotate_from_serial(co[0]),
        .key_scan_output_mode(co[1]), .timer_run(co[2]),
        .carrier_div12(co[3]), .carrier_duty_third(duty3),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rry));

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // A spent bound counts as a mismatch and ends the run
    task automatic lim(input int c);
        if (c >= 40)
        begin
            bad_count++;
            test_done;
        end
    endtask

    // ------------------------------------------------------------------
    // Bus cycles: each starts after an edge, so no signal is set twice
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 40 && !(bv && bry); n++)
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end
        lim(n);
        rs = bresp;
        bry <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 40 && !(rv && rry); n++)
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end
        lim(n);
        rd = rdata;
        rs = rresp;
        rry <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Reference: {reset seen, resume seen} for a halt with key state p
    // ------------------------------------------------------------------
    function automatic logic [1:0] model(input logic [3:0] op,
        input logic [9:0] c, input logic [3:0] h, input logic p);
        if (op[1:0] != SRC_TIMER && p && h[2 - op[1:0]])
            return 2'b10;
        if (op[1:0] == SRC_SERIAL && !c[CTRL_ROT_SRC_BIT])
            return 2'b01;
        if (op[1:0] == SRC_KEYSCAN && c[CTRL_KEY_OUT_BIT])
            return 2'b00;
        return {1'b0, p && !(op[1:0] == SRC_TIMER && op[3])};
    endfunction

    task automatic issue(input logic [3:0] op);
        @(posedge clk);
        sel <= op[1:0];
        lvl <= op[3];
        // Idle slot stands for the no-operation ahead of standby
        @(posedge clk);
        cmd <= '{valid: 1'b1, operand: op};
        @(posedge clk);
        cmd <= '0;
    endtask

    // Records the first resume or reset within c cycles
    task automatic watch(input int c);
        got = 2'b00;
        for (n = 0; n < c && got === 2'b00; n++)
        begin
            @(posedge clk);
            got = {sys_reset, resume};
        end
    endtask

    task automatic halt_case(input logic [3:0] op, input logic [9:0] c,
        input logic [3:0] h);
        wr(OPT_OFS, {8'h00, h, 20'h00000});
        wr(CTRL_OFS, {22'h0, c});
        chk(co, c[3:0]);
        issue(op);
        watch(6);
        chk(got, model(op, c, h, 1'b0));
        if (got === 2'b00)
        begin
            chk(halt, 1'b1);
            press <= 1'b1;
            tdone <= 1'b1;
            @(posedge clk);
            tdone <= 1'b0;
            watch(20);
            chk(got, model(op, c, h, 1'b1));
        end
        if (got === 2'b00 && c[CTRL_KEY_OUT_BIT])
        begin
            wr(CTRL_OFS, 32'h0);
            watch(20);
            chk(got, 2'b01);
        end
        press <= 1'b0;
        repeat (4) @(posedge clk);
        chk(halt, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(4'hc);
        chk(rs, RESP_SLVERR);
        chk(rd, 32'h0);
        // Every source, random level except the timer, then routing, direction and hang-up
        for (i = 0; i < 9; i++)
        begin
            k = $random(seed);
            s = (i < 4) ? i : (i < 6) ? i - 4 : i - 6;
            halt_case({k[0] && s != 3, 1'b0, 2'(s)},
                i == 4 ? 10'h000 : i == 5 ? 10'h003 : 10'h001,
                i > 5 ? 4'(1 << (2 - s)) : 4'h0);
        end
        wr(OPT_OFS, 32'h00001000);
        wr(CTRL_OFS, 32'h008);
        chk(co, 4'h8);
        chk(duty3, 1'b1);
        wr(OPT_OFS, 32'h0);
        chk(duty3, 1'b0);
        // Timer source with high level never releases; all-clear ends it
        issue(4'hb);
        tdone <= 1'b1;
        watch(10);
        tdone <= 1'b0;
        chk(got, 2'b00);
        clr_n <= 1'b0;
        watch(6);
        chk(got, 2'b10);
        clr_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(halt, 1'b0);
        // Oscillator stop waits for the countdown, then restarts on release
        wr(CTRL_OFS, 32'h041);
        busy <= 1'b1;
        issue(4'ha);
        repeat (3) @(posedge clk);
        chk({halt, clk_en}, 2'b11);
        busy <= 1'b0;
        repeat (3) @(posedge clk);
        chk(clk_en, 1'b0);
        press <= 1'b1;
        watch(20);
        chk({got, clk_en}, 3'b011);
        press <= 1'b0;
        rd_reg(CTRL_OFS);
        chk(rd, 32'h041);
        // Key scan left in input mode during stop forces a reset
        wr(OPT_OFS, 32'h00800000);
        issue(4'ha);
        watch(10);
        chk(got, 2'b10);
        wr(OPT_OFS, 32'h0);
        lvd <= 1'b1;
        repeat (2) @(posedge clk);
        chk({tx_ind, sys_reset}, 2'b01);
        lvd <= 1'b0;
        repeat (3) @(posedge clk);
        chk(tx_ind, idle);
        test_done;
    end
endmodule
